// ---- hdl/ifd_pkg.sv ----
// package: instruction field layout, opcodes and timing for the format decoder
package ifd_pkg;
	localparam int IFD_WORD_W = 14;
	localparam int IFD_DATA_W = 8;
	localparam int IFD_ADDR_W = 7;
	// byte-oriented layout
	localparam int IFD_BYTE_OP_LSB = 8;
	localparam int IFD_DEST_POS = 7;
	localparam int IFD_FILE_LSB = 0;
	// bit-oriented layout
	localparam int IFD_BIT_OP_LSB = 10;
	localparam int IFD_BITNUM_LSB = 7;
	// literal layout
	localparam int IFD_LIT_OP_LSB = 8;
	localparam int IFD_LIT_LSB = 0;
	// call and jump layout
	localparam int IFD_JMP_OP_LSB = 11;
	localparam int IFD_TGT_LSB = 0;
	// opcodes of the executed operations
	localparam logic [5:0] IFD_OPC_NIBBLE_EXCHANGE = 6'h0e;
	localparam logic [5:0] IFD_OPC_XOR_ACC_FILE = 6'h06;
	// literal xor: upper bits 1010, bits 9:8 free
	localparam logic [3:0] IFD_OPC_XOR_ACC_LITERAL = 4'ha;
	// reset values
	localparam logic [7:0] IFD_ACC_RST = 8'h00;
	localparam logic IFD_ZERO_RST = 1'b0;
	// one instruction cycle is four oscillator periods
	localparam int IFD_OSC_PER_CYCLE = 4;
	localparam logic [1:0] IFD_PHASE_LAST = 2'(IFD_OSC_PER_CYCLE - 1);

	typedef struct packed {
		logic [5:0] byte_opcode;
		logic dest_file;
		logic [6:0] file_addr;
		logic [3:0] bit_opcode;
		logic [2:0] bit_num;
		logic [5:0] lit_opcode;
		logic [7:0] literal;
		logic [2:0] jmp_opcode;
		logic [10:0] target;
	} ifd_fields_t;

	typedef struct packed {
		logic valid;
		logic [6:0] addr;
		logic [7:0] data;
	} ifd_file_wr_t;
endpackage

// ---- hdl/ifd_field_split.sv ----
// module: splits an instruction word into all format fields
`timescale 1ns/100ps
module ifd_field_split
	import ifd_pkg::*;
(
	// instruction word
	input wire logic [13:0] word,
	// decoded fields
	output ifd_fields_t fields
);
	always_comb begin
		fields = '0;
		fields.byte_opcode = word[13:IFD_BYTE_OP_LSB];
		fields.dest_file = word[IFD_DEST_POS];
		fields.file_addr = word[IFD_FILE_LSB +: IFD_ADDR_W];
		fields.bit_opcode = word[13:IFD_BIT_OP_LSB];
		fields.bit_num = word[IFD_BITNUM_LSB +: 3];
		fields.lit_opcode = word[13:IFD_LIT_OP_LSB];
		fields.literal = word[IFD_LIT_LSB +: IFD_DATA_W];
		fields.jmp_opcode = word[13:IFD_JMP_OP_LSB];
		fields.target = word[IFD_TGT_LSB +: 11];
	end
endmodule

// ---- hdl/ifd_decode_exec.sv ----
// module: instruction format decoder executing nibble exchange and xor operations
`timescale 1ns/100ps
module ifd_decode_exec
	import ifd_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// program memory fetch
	input wire logic [13:0] instr_word,
	input wire logic instr_valid,
	output logic instr_ready,
	// file register read port
	output logic [6:0] file_rd_addr,
	input wire logic [7:0] file_rd_data,
	// file register write port
	output ifd_file_wr_t file_wr,
	// decoded fields
	output ifd_fields_t fields_q,
	// core state
	output logic [7:0] acc_q,
	output logic zero_flag_q,
	output logic done_q
);
	////////////////////////////////////////////////////////////////////////
	// reset asserts at once and is released through two flops
	logic rst_meta_q;
	logic rst_sync_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	ifd_fields_t fields_d;
	ifd_field_split u_split (
		.word(instr_word),
		.fields(fields_d)
	);

	typedef enum logic [1:0] {
		IFD_IDLE,
		IFD_RUN
	} ifd_state_t;
	ifd_state_t state_q;
	logic [1:0] phase_q;
	logic [13:0] word_q;

	// a word is taken only between cycles
	assign instr_ready = (state_q == IFD_IDLE) && rst_sync_q;

	always_ff @(posedge mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			state_q <= IFD_IDLE;
		end else begin
			case (state_q)
				IFD_IDLE: begin
					if (instr_valid) begin
						state_q <= IFD_RUN;
					end
				end
				IFD_RUN: begin
					if (phase_q == IFD_PHASE_LAST - 2'h1) begin
						state_q <= IFD_IDLE;
					end
				end
				default: begin
					state_q <= IFD_IDLE;
				end
			endcase
		end
	end

	// phase counts the periods of one instruction cycle
	always_ff @(posedge mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			phase_q <= 2'h0;
		end else if (instr_ready && instr_valid) begin
			phase_q <= 2'h0;
		end else if (state_q == IFD_RUN) begin
			phase_q <= phase_q + 2'h1;
		end
	end

	// the taken word and its fields stand until the next word is taken
	always_ff @(posedge mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			word_q <= 14'h0000;
			fields_q <= '0;
		end else if (instr_ready && instr_valid) begin
			word_q <= instr_word;
			fields_q <= fields_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		IFD_OP_NONE,
		IFD_OP_NIBBLE_EXCHANGE,
		IFD_OP_XOR_ACC_FILE,
		IFD_OP_XOR_ACC_LITERAL
	} ifd_op_t;
	ifd_op_t op_kind;
	logic [7:0] swapped;
	logic [7:0] result;
	logic result_zero;
	logic writes_zero;
	logic exec_now;
	logic acc_we;
	logic file_we;

	// operation decode of the held word; any other word changes no state
	always_comb begin
		op_kind = IFD_OP_NONE;
		if (word_q[13:IFD_BYTE_OP_LSB] == IFD_OPC_NIBBLE_EXCHANGE) begin
			op_kind = IFD_OP_NIBBLE_EXCHANGE;
		end else if (word_q[13:IFD_BYTE_OP_LSB] == IFD_OPC_XOR_ACC_FILE) begin
			op_kind = IFD_OP_XOR_ACC_FILE;
		end else if (word_q[13:IFD_LIT_OP_LSB + 2] == IFD_OPC_XOR_ACC_LITERAL) begin
			op_kind = IFD_OP_XOR_ACC_LITERAL;
		end
	end

	// each result bit takes the matching bit of the other nibble
	for (genvar b = 0; b < IFD_DATA_W; b++) begin : g_swap
		assign swapped[b] = file_rd_data[(b + IFD_DATA_W / 2) % IFD_DATA_W];
	end

	always_comb begin
		result = 8'h00;
		writes_zero = 1'b0;
		case (op_kind)
			IFD_OP_NIBBLE_EXCHANGE: begin
				result = swapped;
			end
			IFD_OP_XOR_ACC_FILE: begin
				result = acc_q ^ file_rd_data;
				writes_zero = 1'b1;
			end
			IFD_OP_XOR_ACC_LITERAL: begin
				result = acc_q ^ fields_q.literal;
				writes_zero = 1'b1;
			end
			default: begin
				result = 8'h00;
				writes_zero = 1'b0;
			end
		endcase
	end

	assign result_zero = (result == 8'h00);

	// destination select steers the byte operations, literal xor always hits the accumulator
	always_comb begin
		acc_we = 1'b0;
		file_we = 1'b0;
		case (op_kind)
			IFD_OP_NIBBLE_EXCHANGE, IFD_OP_XOR_ACC_FILE: begin
				acc_we = !fields_q.dest_file;
				file_we = fields_q.dest_file;
			end
			IFD_OP_XOR_ACC_LITERAL: begin
				acc_we = 1'b1;
			end
			default: begin
				acc_we = 1'b0;
				file_we = 1'b0;
			end
		endcase
	end

	// results commit at the end of phase 2, the third phase of the four-period cycle
	assign exec_now = (state_q == IFD_RUN) && (phase_q == IFD_PHASE_LAST - 2'h1);
	assign file_rd_addr = fields_q.file_addr;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			acc_q <= IFD_ACC_RST;
		end else if (exec_now && acc_we) begin
			acc_q <= result;
		end
	end

	// nibble exchange never writes the flag
	always_ff @(posedge mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			zero_flag_q <= IFD_ZERO_RST;
		end else if (exec_now && writes_zero) begin
			zero_flag_q <= result_zero;
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			file_wr <= '0;
		end else begin
			file_wr.valid <= exec_now && file_we;
			file_wr.addr <= fields_q.file_addr;
			file_wr.data <= result;
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			done_q <= 1'b0;
		end else begin
			done_q <= exec_now;
		end
	end
endmodule

// ---- tb/ifd_file_model.sv ----
// partner: file register array, combinational read, written on file_wr pulses
`timescale 1ns/100ps
module ifd_file_model
	import ifd_pkg::*;
(
	// clock
	input wire logic mclk,
	// file ports
	input wire logic [6:0] rd_addr,
	output logic [7:0] rd_data,
	input ifd_file_wr_t wr
);
	logic [7:0] mem [128];
	initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 5);
	always @(posedge mclk) if (wr.valid) mem[wr.addr] <= wr.data;
	assign rd_data = mem[rd_addr];
endmodule

// ---- tb/ifd_props.sv ----
// checker: timing and result relations at the decoder ports
`timescale 1ns/100ps
module ifd_props
	import ifd_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// fetch and file ports
	input wire logic [13:0] instr_word,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic [6:0] file_rd_addr,
	input wire logic [7:0] file_rd_data,
	input ifd_file_wr_t file_wr,
	// results
	input ifd_fields_t fields_q,
	input wire logic [7:0] acc_q,
	input wire logic zero_flag_q,
	input wire logic done_q
);
	logic tk, sw, xf, xl;
	assign tk = instr_valid && instr_ready;
	assign sw = tk && instr_word[13:8] == IFD_OPC_NIBBLE_EXCHANGE;
	assign xf = tk && instr_word[13:8] == IFD_OPC_XOR_ACC_FILE;
	assign xl = tk && instr_word[13:10] == IFD_OPC_XOR_ACC_LITERAL;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	a_cycle_len: assert property (tk |=> !instr_ready[*3] ##1 (done_q && instr_ready))
		else $error("instruction cycle length wrong");
	a_byte_fields: assert property (tk |=> fields_q.file_addr == $past(instr_word[6:0])
		&& file_rd_addr == $past(instr_word[6:0]) && fields_q.bit_num == $past(instr_word[9:7]))
		else $error("byte or bit fields wrong");
	a_lit_fields: assert property (tk |=> fields_q.literal == $past(instr_word[7:0])
		&& fields_q.target == $past(instr_word[10:0])) else $error("literal fields wrong");
	a_swap_acc: assert property (sw && !instr_word[7] |->
		##4 acc_q == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])}) else $error("swap");
	a_swap_flag: assert property (sw |-> ##4 zero_flag_q == $past(zero_flag_q, 4))
		else $error("swap changed zero flag");
	a_xor_wback: assert property (xf && instr_word[7] |-> ##4 file_wr.valid
		&& file_wr.data == (acc_q ^ $past(file_rd_data))) else $error("file xor write");
	a_lit_xor: assert property (xl |-> ##4 acc_q == ($past(acc_q, 4) ^ $past(instr_word[7:0], 4))
		&& zero_flag_q == (acc_q == 8'h00) && !file_wr.valid) else $error("literal xor");
	a_wr_done: assert property (file_wr.valid |-> done_q) else $error("write off cycle end");
	a_swap_wback: assert property (sw && instr_word[7] |-> ##4 file_wr.valid
		&& file_wr.data == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])}
		&& file_wr.addr == $past(instr_word[6:0], 4) && acc_q == $past(acc_q, 4))
		else $error("swap write back wrong");
	a_xor_acc: assert property (xf && !instr_word[7] |-> ##4 !file_wr.valid
		&& acc_q == ($past(acc_q, 4) ^ $past(file_rd_data)) && zero_flag_q == (acc_q == 8'h00))
		else $error("file xor into accumulator wrong");
	cover property (sw && instr_word[7]);
	cover property (sw && !instr_word[7]);
	cover property (xf && !instr_word[7]);
	cover property (xl ##4 zero_flag_q);
endmodule
bind ifd_decode_exec ifd_props i_props (.mclk, .resetn, .instr_word, .instr_valid, .instr_ready,
	.file_rd_addr, .file_rd_data, .file_wr, .fields_q, .acc_q, .zero_flag_q, .done_q);

// ---- tb/test_instr_format_decode_swap_xor.sv ----
// testbench: random decode and execute traffic against an integer model
`timescale 1ns/100ps
module test_instr_format_decode_swap_xor
	import ifd_pkg::*;
;
	logic mclk = 0, resetn = 0, instr_valid = 0, instr_ready, zero_flag_q, done_q;
	logic [13:0] instr_word = '0;
	logic [6:0] file_rd_addr;
	logic [7:0] file_rd_data, acc_q;
	logic [31:0] s = 32'h00017ca8;
	ifd_file_wr_t file_wr;
	ifd_fields_t fields_q;
	int fail_count = 0, n_tests = 0, acc = 0, mem [128];
	bit z = 0;
	always #4 mclk = ~mclk;
	ifd_decode_exec i_dut (.mclk, .resetn, .instr_word, .instr_valid, .instr_ready,
		.file_rd_addr, .file_rd_data, .file_wr, .fields_q, .acc_q, .zero_flag_q, .done_q);
	ifd_file_model i_file (.mclk, .rd_addr(file_rd_addr), .rd_data(file_rd_data), .wr(file_wr));
	function automatic logic [31:0] xs();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task chk(input bit ok, input string m);
		n_tests++;
		if (!ok) begin
			fail_count++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task run(input logic [13:0] w);
		int r, d, k;
		bit wv;
		d = mem[w[6:0]];
		r = -1;
		if (w[13:8] == 6'h0e) r = d % 16 * 16 + d / 16;
		if (w[13:8] == 6'h06) r = acc ^ d;
		if (w[13:10] == 4'ha) r = acc ^ w[7:0];
		wv = r >= 0 && w[13:12] == 2'h0 && w[7];
		if (r >= 0 && w[13:8] != 6'h0e) z = r == 0;
		if (wv) mem[w[6:0]] = r;
		else if (r >= 0) acc = r;
		@(posedge mclk);
		instr_word <= w;
		instr_valid <= 1'b1;
		do @(posedge mclk); while (instr_ready !== 1'b1);
		instr_valid <= 1'b0;
		k = 0;
		do begin
			@(posedge mclk);
			#1;
			k++;
		end while (done_q !== 1'b1 && k < 9);
		// the taking edge and three more make the four periods of one cycle
		chk(k == IFD_OSC_PER_CYCLE - 1, "cycle count");
		chk(fields_q === {w[13:8], w[7], w[6:0], w[13:10], w[9:7], w[13:8], w[7:0],
			w[13:11], w[10:0]}, "fields");
		chk(acc_q === 8'(acc) && zero_flag_q === z, "acc or zero");
		chk(file_wr.valid === wv && (!wv || file_wr.data === 8'(r)
			&& file_wr.addr === w[6:0]), "file write");
	endtask
	initial begin
		logic [31:0] r;
		for (int i = 0; i < 128; i++) mem[i] = (i * 37 + 5) % 256;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		chk(acc_q === IFD_ACC_RST && zero_flag_q === IFD_ZERO_RST && done_q === 1'b0
			&& instr_ready === 1'b0, "reset");
		$display("test reset done");
		repeat (300) begin
			r = xs();
			case (r[1:0])
				2'h0: run({6'h0e, r[9:2]});
				2'h1: run({6'h06, r[9:2]});
				2'h2: run({4'ha, r[11:10], r[12] ? 8'(acc) : r[9:2]});
				default: run({3'h4, r[12:2]});
			endcase
		end
		$display("test random ops done");
		wrap_up;
	end
	initial begin
		#60000;
		fail_count++;
		wrap_up;
	end
endmodule
